//--- status_override_pkg.sv
// Constants and carrier types for the analogue status override bank.
// Assumes 16-bit registers reached over a 32-bit classic Wishbone port, byte addressed at four times the index.
package status_override_pkg;

    // ==========================================================
    // Register indices and byte address width
    localparam logic [7:0] CHARGER_IDX = 8'hE2;
    localparam logic [7:0] MISC_IDX = 8'hE3;
    localparam logic [7:0] SUPPLY_OV_IDX = 8'hE4;
    localparam logic [7:0] SUPPLY_UV_OC_IDX = 8'hE5;
    localparam logic [7:0] MASTER_IDX = 8'hF0;
    localparam int ADDR_W = 10;

    // ==========================================================
    // Writable bit masks per register
    localparam logic [15:0] CHARGER_MASK = 16'hC807;
    localparam logic [15:0] MISC_MASK = 16'h14FE;
    localparam logic [15:0] SUPPLY_OV_MASK = 16'h000D;
    localparam logic [15:0] SUPPLY_UV_MASK = 16'h0F0F;
    localparam logic [15:0] SUPPLY_OC_MASK = 16'h8000;
    localparam logic [15:0] MASTER_MASK = 16'h000F;
    localparam logic [15:0] RESET_VALUE = 16'h0000;

    // ==========================================================
    // Master force bit positions
    localparam int GENERAL_POS = 0;
    localparam int OV_POS = 1;
    localparam int UV_POS = 2;
    localparam int OC_POS = 3;

    // ==========================================================
    // Carrier of the four status words
    typedef struct packed {
        logic [15:0] charger;
        logic [15:0] misc;
        logic [15:0] supply_ov;
        logic [15:0] supply_uv_oc;
    } status_set_t;

endpackage

//--- force_select.sv
// Per-bit selection between raw monitor value and software forced value.
// Assumes the enable mask is stable within the cycle it is applied.
`timescale 1ns/10ps
module force_select (
    input wire logic [15:0] raw_i,
    input wire logic [15:0] forced_i,
    input wire logic [15:0] enable_i,
    output logic [15:0] out_o
);
    // ==========================================================
    // Selection
    genvar b;
    generate
        for (b = 0; b < 16; b++) begin : g_bit
            assign out_o[b] = enable_i[b] ? forced_i[b] : raw_i[b];
        end
    endgenerate
endmodule

//--- analog_status_override_bank.sv
// Analogue status override bank between monitor comparators and debounce logic.
// Assumes raw status inputs already synchronous to clk_i; registers on classic Wishbone.
`timescale 1ns/10ps
module analog_status_override_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [status_override_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire status_override_pkg::status_set_t raw_i,
    output status_override_pkg::status_set_t debounce_o
);
    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [status_override_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    logic req;
    logic sel_chg;
    logic sel_misc;
    logic sel_ov;
    logic sel_uv;
    logic sel_mst;
    logic mapped;
    logic wr_lo;
    logic wr_hi;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign sel_chg = hit(wb_adr_i, status_override_pkg::CHARGER_IDX);
    assign sel_misc = hit(wb_adr_i, status_override_pkg::MISC_IDX);
    assign sel_ov = hit(wb_adr_i, status_override_pkg::SUPPLY_OV_IDX);
    assign sel_uv = hit(wb_adr_i, status_override_pkg::SUPPLY_UV_OC_IDX);
    assign sel_mst = hit(wb_adr_i, status_override_pkg::MASTER_IDX);
    assign mapped = sel_chg | sel_misc | sel_ov | sel_uv | sel_mst;
    assign wr_lo = req & mapped & wb_we_i & wb_sel_i[0];
    assign wr_hi = req & mapped & wb_we_i & wb_sel_i[1];

    // ==========================================================
    // Storage
    status_override_pkg::status_set_t forced_reg;
    logic [15:0] master_reg;
    logic [15:0] wmask;
    logic [15:0] wval;
    assign wmask = {{8{wr_hi}}, {8{wr_lo}}};
    assign wval = wb_dat_i[15:0];

    function automatic logic [15:0] upd(input logic [15:0] old, input logic [15:0] m,
                                        input logic [15:0] v, input logic s);
        upd = s ? ((old & ~m) | (v & m)) : old;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            forced_reg <= '0;
            master_reg <= status_override_pkg::RESET_VALUE;
        end else begin
            forced_reg.charger <= upd(forced_reg.charger,
                wmask & status_override_pkg::CHARGER_MASK, wval, sel_chg);
            forced_reg.misc <= upd(forced_reg.misc,
                wmask & status_override_pkg::MISC_MASK, wval, sel_misc);
            forced_reg.supply_ov <= upd(forced_reg.supply_ov,
                wmask & status_override_pkg::SUPPLY_OV_MASK, wval, sel_ov);
            forced_reg.supply_uv_oc <= upd(forced_reg.supply_uv_oc, wmask
                & (status_override_pkg::SUPPLY_UV_MASK | status_override_pkg::SUPPLY_OC_MASK),
                wval, sel_uv);
            master_reg <= upd(master_reg, wmask & status_override_pkg::MASTER_MASK,
                wval, sel_mst);
        end
    end

    // ==========================================================
    // Override enables
    logic gen_m;
    logic ov_m;
    logic uv_m;
    logic oc_m;
    status_override_pkg::status_set_t en;
    assign gen_m = master_reg[status_override_pkg::GENERAL_POS];
    assign ov_m = master_reg[status_override_pkg::OV_POS];
    assign uv_m = master_reg[status_override_pkg::UV_POS];
    assign oc_m = master_reg[status_override_pkg::OC_POS];
    assign en.charger = {16{gen_m}} & status_override_pkg::CHARGER_MASK;
    assign en.misc = {16{gen_m}} & status_override_pkg::MISC_MASK;
    assign en.supply_ov = {16{ov_m}} & status_override_pkg::SUPPLY_OV_MASK;
    assign en.supply_uv_oc = ({16{uv_m}} & status_override_pkg::SUPPLY_UV_MASK)
        | ({16{oc_m}} & status_override_pkg::SUPPLY_OC_MASK);

    // Debounce feed: forced where enabled, raw otherwise
    force_select u_sel_chg (.raw_i(raw_i.charger), .forced_i(forced_reg.charger),
        .enable_i(en.charger), .out_o(debounce_o.charger));
    force_select u_sel_misc (.raw_i(raw_i.misc), .forced_i(forced_reg.misc),
        .enable_i(en.misc), .out_o(debounce_o.misc));
    force_select u_sel_ov (.raw_i(raw_i.supply_ov), .forced_i(forced_reg.supply_ov),
        .enable_i(en.supply_ov), .out_o(debounce_o.supply_ov));
    force_select u_sel_uv (.raw_i(raw_i.supply_uv_oc), .forced_i(forced_reg.supply_uv_oc),
        .enable_i(en.supply_uv_oc), .out_o(debounce_o.supply_uv_oc));

    // ==========================================================
    // Read data: raw when master clear, forced value when set
    status_override_pkg::status_set_t rd;
    logic [15:0] rd_word;
    assign rd.charger = debounce_o.charger & status_override_pkg::CHARGER_MASK;
    assign rd.misc = debounce_o.misc & status_override_pkg::MISC_MASK;
    assign rd.supply_ov = debounce_o.supply_ov & status_override_pkg::SUPPLY_OV_MASK;
    assign rd.supply_uv_oc = debounce_o.supply_uv_oc
        & (status_override_pkg::SUPPLY_UV_MASK | status_override_pkg::SUPPLY_OC_MASK);
    assign rd_word = sel_chg ? rd.charger :
                     sel_misc ? rd.misc :
                     sel_ov ? rd.supply_ov :
                     sel_uv ? rd.supply_uv_oc :
                     sel_mst ? master_reg : 16'h0000;

    // ==========================================================
    // Bus answer, one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req & mapped;
            wb_err_o <= req & ~mapped;
            wb_dat_o <= (req & mapped & ~wb_we_i) ? {16'h0000, rd_word} : 32'h00000000;
        end
    end

    // ==========================================================
    // Checks
    property p_raw_read;
        @(posedge clk_i) disable iff (rst_i)
        req & sel_chg & ~wb_we_i & ~gen_m |=> wb_dat_o[15:0]
            == ($past(raw_i.charger) & status_override_pkg::CHARGER_MASK);
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("charger read not raw");
    property p_general;
        @(posedge clk_i) disable iff (rst_i)
        gen_m |-> debounce_o.misc[12] == forced_reg.misc[12]
            && debounce_o.charger[15] == forced_reg.charger[15];
    endproperty
    a_general: assert property (p_general) else $error("general force ignored");
    property p_ov;
        @(posedge clk_i) disable iff (rst_i)
        ov_m |-> debounce_o.supply_ov[3:2] == forced_reg.supply_ov[3:2]
            && debounce_o.supply_ov[0] == forced_reg.supply_ov[0];
    endproperty
    a_ov: assert property (p_ov) else $error("overvoltage force ignored");
    property p_uv;
        @(posedge clk_i) disable iff (rst_i)
        uv_m |-> debounce_o.supply_uv_oc[11:8] == forced_reg.supply_uv_oc[11:8]
            && debounce_o.supply_uv_oc[3:0] == forced_reg.supply_uv_oc[3:0];
    endproperty
    a_uv: assert property (p_uv) else $error("undervoltage force ignored");
    property p_oc;
        @(posedge clk_i) disable iff (rst_i)
        oc_m |-> debounce_o.supply_uv_oc[15] == forced_reg.supply_uv_oc[15];
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent force ignored");
    property p_raw_pass;
        @(posedge clk_i) disable iff (rst_i)
        ~gen_m & ~ov_m & ~uv_m & ~oc_m |-> debounce_o == raw_i;
    endproperty
    a_raw_pass: assert property (p_raw_pass) else $error("raw not passed");
    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> ~wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
    property p_write_effect;
        @(posedge clk_i) disable iff (rst_i)
        wr_lo & sel_mst |=> master_reg[3:0] == $past(wb_dat_i[3:0]);
    endproperty
    a_write_effect: assert property (p_write_effect) else $error("master write lost");
    property p_raw_read_misc;
        @(posedge clk_i) disable iff (rst_i)
        req & sel_misc & ~wb_we_i & ~gen_m |=> wb_dat_o[15:0]
            == ($past(raw_i.misc) & status_override_pkg::MISC_MASK);
    endproperty
    a_raw_read_misc: assert property (p_raw_read_misc) else $error("misc not raw");
    property p_general_pass;
        @(posedge clk_i) disable iff (rst_i)
        ~gen_m |-> debounce_o.charger == raw_i.charger && debounce_o.misc == raw_i.misc;
    endproperty
    a_general_pass: assert property (p_general_pass) else $error("general group forced");
    property p_ov_pass;
        @(posedge clk_i) disable iff (rst_i)
        ~ov_m |-> debounce_o.supply_ov == raw_i.supply_ov;
    endproperty
    a_ov_pass: assert property (p_ov_pass) else $error("overvoltage group forced");
    property p_uv_oc_pass;
        @(posedge clk_i) disable iff (rst_i)
        ~uv_m & ~oc_m |-> debounce_o.supply_uv_oc == raw_i.supply_uv_oc;
    endproperty
    a_uv_oc_pass: assert property (p_uv_oc_pass) else $error("supply group forced");
    property p_err_once;
        @(posedge clk_i) disable iff (rst_i)
        wb_err_o |=> ~wb_err_o;
    endproperty
    a_err_once: assert property (p_err_once) else $error("err held two cycles");
    property p_unmapped_quiet;
        @(posedge clk_i) disable iff (rst_i)
        req & ~mapped |=> $stable(master_reg) && $stable(forced_reg);
    endproperty
    a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("unmapped write landed");
    property p_dat_idle;
        @(posedge clk_i) disable iff (rst_i)
        ~wb_ack_o |-> wb_dat_o == 32'h00000000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
    c_general: cover property (@(posedge clk_i) $rose(gen_m));
    c_ov: cover property (@(posedge clk_i) $rose(ov_m));
    c_uv: cover property (@(posedge clk_i) $rose(uv_m));
    c_oc: cover property (@(posedge clk_i) $rose(oc_m));
    c_err: cover property (@(posedge clk_i) wb_err_o);
endmodule

//--- analog_status_override_bank_tb.sv
// Self-checking bench for the analogue status override bank.
// Assumes the Wishbone timing and the master index given in the package.
`timescale 1ns/10ps
module analog_status_override_bank_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [status_override_pkg::ADDR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic wb_err_o;
    status_override_pkg::status_set_t raw_i = '0;
    status_override_pkg::status_set_t debounce_o;
    int err_total = 0;
    int samples_checked = 0;
    logic [15:0] rd;
    logic er;
    logic [63:0] raw_v, frc, expv;
    logic [15:0] mk [4];
    logic [3:0] m;
    logic [3:0] lane = 4'h3;

    analog_status_override_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .raw_i(raw_i), .debounce_o(debounce_o));

    // ==========================================================
    // Clock and watchdog
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end

    // ==========================================================
    // Tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic access(input logic we, input logic [7:0] idx, input logic [15:0] wd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= lane;
        wb_dat_i <= {16'h0000, wd};
        do begin
            @(posedge clk_i);
        end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1));
        rd = wb_dat_o[15:0];
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    function automatic logic [63:0] fexp(input logic [63:0] r, input logic [63:0] f,
                                         input logic [3:0] mm);
        logic [63:0] fm;
        fm = {{16{mm[status_override_pkg::GENERAL_POS]}} & status_override_pkg::CHARGER_MASK,
              {16{mm[status_override_pkg::GENERAL_POS]}} & status_override_pkg::MISC_MASK,
              {16{mm[status_override_pkg::OV_POS]}} & status_override_pkg::SUPPLY_OV_MASK,
              ({16{mm[status_override_pkg::UV_POS]}} & status_override_pkg::SUPPLY_UV_MASK)
              | ({16{mm[status_override_pkg::OC_POS]}} & status_override_pkg::SUPPLY_OC_MASK)};
        return (r & ~fm) | (f & fm);
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        mk[0] = status_override_pkg::CHARGER_MASK;
        mk[1] = status_override_pkg::MISC_MASK;
        mk[2] = status_override_pkg::SUPPLY_OV_MASK;
        mk[3] = status_override_pkg::SUPPLY_UV_MASK | status_override_pkg::SUPPLY_OC_MASK;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            raw_v = (p == 0) ? 64'h3C96_A5F0_0F5A_C3E1 : 64'hC369_5A0F_F0A5_3C1E;
            raw_i <= raw_v;
            frc = ~raw_v;
            access(1'b1, status_override_pkg::MASTER_IDX, 16'h0000);
            for (int r = 0; r < 4; r++) begin
                access(1'b1, 8'(status_override_pkg::CHARGER_IDX + r), frc[63-16*r -: 16]);
            end
            for (int k = 0; k < 6; k++) begin
                m = (k == 0) ? 4'h0 : (k == 5) ? 4'hF : 4'(1 << (k - 1));
                access(1'b1, status_override_pkg::MASTER_IDX, {12'h000, m});
                @(negedge clk_i);
                expv = fexp(raw_v, frc, m);
                check(debounce_o, expv);
                for (int r = 0; r < 4; r++) begin
                    access(1'b0, 8'(status_override_pkg::CHARGER_IDX + r), 16'h0000);
                    check(64'(rd & mk[r]), 64'(expv[63-16*r -: 16] & mk[r]));
                end
            end
        end
        access(1'b1, status_override_pkg::MASTER_IDX, 16'h0005);
        lane = 4'h2;
        access(1'b1, status_override_pkg::MASTER_IDX, 16'h000A);
        lane = 4'h3;
        @(negedge clk_i);
        check(debounce_o, fexp(raw_v, frc, 4'h5));
        access(1'b0, status_override_pkg::MASTER_IDX, 16'h0000);
        check(64'(rd), 64'h5);
        access(1'b0, 8'h10, 16'h0000);
        check(64'(er), 64'h1);
        tally_and_finish();
    end
endmodule
